// File: shared/ephy_pkg.sv
// Constants, register map and carrier types for the PHY pin interface.
// Assumes one system clock domain; all pin timing is derived by sampling.
package ephy_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [3:0] EPHY_CTRL_ADDR = 4'h0;
	localparam logic [3:0] EPHY_STAT_ADDR = 4'h4;
	localparam logic [3:0] EPHY_RXCNT_ADDR = 4'h8;
	localparam int EPHY_STAT_COLSEEN_BIT = 3;
	localparam logic [31:0] EPHY_RD_ZERO = 32'h0000_0000;

	// ****************************************
	// Frame and pin constants
	// ****************************************
	localparam int EPHY_DA_BYTES = 6;
	localparam logic [7:0] EPHY_SFD = 8'hd5;
	localparam logic [2:0] EPHY_MII_LAST = 3'h1;
	localparam logic [2:0] EPHY_SER_LAST = 3'h7;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic pc_low;
		logic pc_miss;
		logic loopback;
		logic serial;
	} ephy_ctrl_s;

	localparam ephy_ctrl_s EPHY_CTRL_RST = 4'h0;

	typedef struct packed {
		logic col_seen;
		logic link;
		logic col;
		logic crs;
	} ephy_stat_s;

	typedef struct packed {
		logic tx_clk;
		logic rx_clk;
		logic [3:0] rxd;
		logic rx_dv;
		logic rx_err;
		logic crs;
		logic col;
	} ephy_pins_s;

	localparam ephy_pins_s EPHY_PINS_RST = 10'h000;

	typedef enum logic [1:0] {
		EPHY_HUNT = 2'b00,
		EPHY_DA = 2'b01,
		EPHY_BODY = 2'b11
	} ephy_rx_e;

endpackage

// File: hw/ephy_sync2.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is a level held long enough to be seen by clk_sys.
`timescale 1ns/10ps
module ephy_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("ephy_sync2 width must be at least one");
		end
	endgenerate

	// First stage is read only by the second
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// File: hw/ephy_pin_if.sv
// PHY-side pin interface: MII nibble mode and 7-wire 10-Mbit serial mode.
// Assumes PHY clocks far slower than clk_sys; software on Avalon-MM.
//
// Contract
// - Transmit data and enable change only at transmit clock rise
// - Bytes leave as two nibbles, low first
// - Serial mode sends stream on data bit zero
// - Serial mode drives loopback bit on bit one
// - Transmit enable covers exactly the frame nibbles
// - Serial mode raises enable when transfer begins
// - Transmit error follows transmit clock in MII mode; PHY corrupts
// - Compress output set right after address taken
// - Compress on address match or miss, selectable
// - Compress polarity configurable independently
// - Serial carrier also gates own transmission
// - Receive pins sampled on receive clock rise
// - Received bytes built from nibbles, low first
`timescale 1ns/10ps
module ephy_pin_if #(
	parameter int DA_BYTES = ephy_pkg::EPHY_DA_BYTES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic phy_tx_clk,
	output logic [3:0] phy_txd,
	output logic phy_tx_en,
	output logic phy_tx_err,
	input wire logic phy_rx_clk,
	input wire logic [3:0] phy_rxd,
	input wire logic phy_rx_dv,
	input wire logic phy_rx_err,
	input wire logic phy_crs,
	input wire logic phy_col,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_err,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_err,
	output logic rx_end,
	input wire logic cam_hit
);
	import ephy_pkg::*;

	generate
		if (DA_BYTES < 1 || DA_BYTES > 15) begin : g_bad_da
			$error("DA_BYTES must lie between 1 and 15");
		end
	endgenerate

	// ****************************************
	// Pin synchronisation
	// ****************************************
	ephy_pins_s pin_raw;
	ephy_pins_s pin_s;
	logic tx_clk_prev_reg;
	logic rx_clk_prev_reg;

	assign pin_raw = '{tx_clk: phy_tx_clk, rx_clk: phy_rx_clk, rxd: phy_rxd,
		rx_dv: phy_rx_dv, rx_err: phy_rx_err, crs: phy_crs, col: phy_col};

	// Clocks, data and carrier share one depth so their skew stays fixed
	ephy_sync2 #(
		.WIDTH($bits(ephy_pins_s))
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.async_in(pin_raw),
		.sync_out(pin_s)
	);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_clk_prev_reg <= 1'b0;
			rx_clk_prev_reg <= 1'b0;
		end else begin
			tx_clk_prev_reg <= pin_s.tx_clk;
			rx_clk_prev_reg <= pin_s.rx_clk;
		end
	end

	wire tx_edge = pin_s.tx_clk & ~tx_clk_prev_reg;
	wire rx_edge = pin_s.rx_clk & ~rx_clk_prev_reg;

	// ****************************************
	// Register bus
	// ****************************************
	ephy_ctrl_s ctrl_reg;
	ephy_stat_s stat_now;
	logic col_seen_reg;
	logic [15:0] rx_frames_reg;
	logic [31:0] rd_mux;

	wire bus_req = avs_read | avs_write;
	wire bus_take = bus_req & avs_waitrequest;
	wire bus_fire = bus_req & ~avs_waitrequest;
	wire wr_ctrl = bus_fire & avs_write & (avs_address == EPHY_CTRL_ADDR);
	wire wr_stat = bus_fire & avs_write & (avs_address == EPHY_STAT_ADDR);
	wire col_clr = wr_stat & avs_writedata[EPHY_STAT_COLSEEN_BIT];
	// Set wins so a collision during the clear is kept
	wire col_seen_next = pin_s.col | (col_seen_reg & ~col_clr);

	assign stat_now = '{col_seen: col_seen_reg, link: ctrl_reg.serial & pin_s.rx_dv,
		col: pin_s.col, crs: pin_s.crs};
	assign rd_mux = (avs_address == EPHY_CTRL_ADDR) ? {28'h0000000, ctrl_reg} :
		(avs_address == EPHY_STAT_ADDR) ? {28'h0000000, stat_now} :
		(avs_address == EPHY_RXCNT_ADDR) ? {16'h0000, rx_frames_reg} : EPHY_RD_ZERO;

	// One wait cycle per access; read data latched as the wait drops
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= EPHY_RD_ZERO;
			ctrl_reg <= EPHY_CTRL_RST;
			col_seen_reg <= 1'b0;
		end else begin
			avs_waitrequest <= ~bus_take;
			if (bus_take) begin
				avs_readdata <= rd_mux;
			end
			if (wr_ctrl) begin
				ctrl_reg <= avs_writedata[$bits(ephy_ctrl_s)-1:0];
			end
			col_seen_reg <= col_seen_next;
		end
	end

	// ****************************************
	// Transmit path
	// ****************************************
	logic hold_valid_reg;
	logic [7:0] hold_data_reg;
	logic hold_err_reg;
	logic [7:0] shift_reg;
	logic [2:0] piece_cnt_reg;
	logic byte_err_reg;

	wire [2:0] last_piece = ctrl_reg.serial ? EPHY_SER_LAST : EPHY_MII_LAST;
	wire tx_more = piece_cnt_reg != 3'h0;
	// A new frame in serial mode waits while the carrier is up
	wire tx_load = hold_valid_reg & ~tx_more &
		(phy_tx_en | ~(ctrl_reg.serial & pin_s.crs));
	wire tx_go = tx_load | tx_more;
	wire [7:0] shift_next = tx_load ? hold_data_reg :
		ctrl_reg.serial ? (shift_reg >> 1) : (shift_reg >> 4);
	wire [3:0] txd_busy = ctrl_reg.serial ?
		{2'b00, ctrl_reg.loopback, shift_next[0]} : shift_next[3:0];
	wire [3:0] txd_idle = ctrl_reg.serial ? {2'b00, ctrl_reg.loopback, 1'b0} : 4'h0;
	wire accept = tx_valid & tx_ready;
	wire hold_valid_next = accept | (hold_valid_reg & ~(tx_edge & tx_load));
	wire byte_err_next = tx_load ? hold_err_reg : byte_err_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hold_valid_reg <= 1'b0;
			hold_data_reg <= 8'h00;
			hold_err_reg <= 1'b0;
			tx_ready <= 1'b0;
		end else begin
			hold_valid_reg <= hold_valid_next;
			tx_ready <= ~hold_valid_next;
			if (accept) begin
				hold_data_reg <= tx_data;
				hold_err_reg <= tx_err;
			end
		end
	end

	// Pins move only at a transmit clock rise
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			shift_reg <= 8'h00;
			piece_cnt_reg <= 3'h0;
			byte_err_reg <= 1'b0;
			phy_txd <= 4'h0;
			phy_tx_en <= 1'b0;
		end else if (tx_edge && tx_go) begin
			shift_reg <= shift_next;
			piece_cnt_reg <= tx_load ? last_piece : piece_cnt_reg - 3'h1;
			byte_err_reg <= byte_err_next;
			phy_txd <= txd_busy;
			phy_tx_en <= 1'b1;
		end else if (tx_edge) begin
			byte_err_reg <= 1'b0;
			phy_txd <= txd_idle;
			phy_tx_en <= 1'b0;
		end
	end

	// ****************************************
	// Receive path
	// ****************************************
	ephy_rx_e rx_state_reg;
	logic [7:0] asm_reg;
	logic [2:0] rx_cnt_reg;
	logic rx_was_reg;
	logic err_acc_reg;
	logic [3:0] da_cnt_reg;
	logic compress_signal_reg;

	wire rx_active = ctrl_reg.serial ? pin_s.crs : pin_s.rx_dv;
	wire [7:0] asm_next = ctrl_reg.serial ? {pin_s.rxd[0], asm_reg[7:1]} :
		{pin_s.rxd, asm_reg[7:4]};
	wire rx_done = rx_edge & rx_active & (rx_cnt_reg == last_piece);
	wire rx_stop = rx_edge & ~rx_active & rx_was_reg;
	wire err_now = err_acc_reg | pin_s.rx_err;
	wire da_last = da_cnt_reg == 4'(DA_BYTES - 1);
	wire da_taken = rx_done & (rx_state_reg == EPHY_DA) & da_last;
	wire compress_signal_hit = ctrl_reg.pc_miss ? ~cam_hit : cam_hit;
	wire compress_signal_next = rx_stop ? 1'b0 : (da_taken ? compress_signal_hit : compress_signal_reg);
	wire compress_signal_pin = compress_signal_next ^ ctrl_reg.pc_low;
	// Shared error pin: compress flag in serial mode, byte error otherwise
	wire tx_err_next = ctrl_reg.serial ? compress_signal_pin :
		tx_edge ? (tx_go & byte_err_next) : phy_tx_err;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			phy_tx_err <= 1'b0;
			compress_signal_reg <= 1'b0;
		end else begin
			phy_tx_err <= tx_err_next;
			compress_signal_reg <= compress_signal_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			asm_reg <= 8'h00;
			rx_cnt_reg <= 3'h0;
			rx_was_reg <= 1'b0;
			err_acc_reg <= 1'b0;
		end else if (rx_edge) begin
			rx_was_reg <= rx_active;
			if (rx_active) begin
				asm_reg <= asm_next;
				rx_cnt_reg <= rx_done ? 3'h0 : rx_cnt_reg + 3'h1;
				err_acc_reg <= rx_done ? 1'b0 : err_now;
			end else begin
				rx_cnt_reg <= 3'h0;
				err_acc_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_err <= 1'b0;
			rx_end <= 1'b0;
			rx_frames_reg <= 16'h0000;
		end else begin
			rx_valid <= rx_done;
			rx_end <= rx_stop;
			if (rx_done) begin
				rx_data <= asm_next;
				rx_err <= err_now;
			end
			if (rx_stop) begin
				rx_frames_reg <= rx_frames_reg + 16'h0001;
			end
		end
	end

	// Address counting starts after the start-of-frame byte
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_state_reg <= EPHY_HUNT;
			da_cnt_reg <= 4'h0;
		end else if (rx_stop) begin
			rx_state_reg <= EPHY_HUNT;
		end else if (rx_done) begin
			unique case (rx_state_reg)
				EPHY_HUNT: begin
					da_cnt_reg <= 4'h0;
					if (asm_next == EPHY_SFD) begin
						rx_state_reg <= EPHY_DA;
					end
				end
				EPHY_DA: begin
					da_cnt_reg <= da_cnt_reg + 4'h1;
					if (da_last) begin
						rx_state_reg <= EPHY_BODY;
					end
				end
				EPHY_BODY: begin
					rx_state_reg <= EPHY_BODY;
				end
				default: begin
					rx_state_reg <= EPHY_HUNT;
				end
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	chk_txd_edge_only: assert property (!tx_edge |=> $stable(phy_txd) && $stable(phy_tx_en))
		else $error("transmit pins moved without a transmit clock rise");
	chk_low_nibble_first: assert property (tx_edge && tx_load && !ctrl_reg.serial
		|=> phy_txd == $past(hold_data_reg[3:0]) ##0 phy_tx_en)
		else $error("first nibble is not the low nibble");
	chk_serial_lsb: assert property (tx_edge && tx_load && ctrl_reg.serial
		|=> phy_txd[0] == $past(hold_data_reg[0]))
		else $error("serial stream does not start with bit zero");
	chk_loop_pin: assert property (tx_edge && ctrl_reg.serial
		|=> phy_txd[1] == $past(ctrl_reg.loopback))
		else $error("loopback pin does not follow control");
	chk_tx_en_end: assert property (tx_edge && !tx_more && !hold_valid_reg |=> !phy_tx_en)
		else $error("transmit enable held without data");
	chk_defer_carrier: assert property (tx_edge && ctrl_reg.serial && pin_s.crs && !phy_tx_en
		|=> !phy_tx_en)
		else $error("serial frame started under carrier");
	chk_compress_signal_value: assert property (da_taken && ctrl_reg.serial
		|=> phy_tx_err == ($past(compress_signal_hit) ^ $past(ctrl_reg.pc_low)))
		else $error("compress output wrong after address");
	chk_rx_nibble_pair: assert property (rx_done && !ctrl_reg.serial
		|=> rx_valid && rx_data == {$past(pin_s.rxd), $past(asm_reg[7:4])})
		else $error("received byte not built low nibble first");
	chk_col_sticky: assert property (pin_s.col |=> col_seen_reg ##1 (col_seen_reg || $past(col_clr)))
		else $error("collision not held in status");
	chk_bus_answer: assert property (bus_take |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after request");

endmodule

// File: test/ephy_phy_model.sv
// PHY model: free-running link clocks, receive driver, transmit capture.
// Assumes the bench calls send and collide and reads cap_q by hierarchical name.
`timescale 1ns/10ps
module ephy_phy_model (
	output logic phy_tx_clk,
	output logic phy_rx_clk,
	input wire logic [3:0] phy_txd,
	input wire logic phy_tx_en,
	input wire logic phy_tx_err,
	output logic [3:0] phy_rxd,
	output logic phy_rx_dv,
	output logic phy_rx_err,
	output logic phy_crs,
	output logic phy_col
);
	logic [4:0] cap_q[$];
	logic busy;

	// ****************************************
	// Clocks and idle lines
	// ****************************************
	initial begin
		{phy_tx_clk, phy_rx_clk, phy_rxd, phy_rx_dv, phy_crs, busy} = '0;
		phy_rx_err = 1'b0;
		phy_col = 1'b0;
	end
	always #80 phy_tx_clk = ~phy_tx_clk;
	initial begin
		#37;
		forever #80 phy_rx_clk = ~phy_rx_clk;
	end
	// Idle data keeps moving so a stale value never passes for data
	always @(negedge phy_rx_clk) begin
		if (!busy) begin
			phy_rxd <= phy_rxd + 4'h7;
		end
	end

	// ****************************************
	// Transmit capture and receive driver
	// ****************************************
	always @(posedge phy_tx_clk) begin
		if (phy_tx_en === 1'b1) begin
			cap_q.push_back({phy_tx_err, phy_txd});
		end
	end
	task automatic send(input logic [8:0] b[$], input logic ser);
		busy = 1'b1;
		foreach (b[i]) begin
			for (int k = 0; k < (ser ? 8 : 2); k++) begin
				@(negedge phy_rx_clk);
				phy_rxd <= ser ? {3'h0, b[i][k]} : b[i][k*4 +: 4];
				phy_rx_dv <= 1'b1;
				phy_rx_err <= b[i][8];
				phy_crs <= 1'b1;
			end
		end
		@(negedge phy_rx_clk);
		// Serial mode keeps link up on the shared valid pin
		phy_rx_dv <= ser;
		phy_rx_err <= 1'b0;
		phy_crs <= 1'b0;
		busy = 1'b0;
	endtask
	task automatic collide(input int n);
		@(negedge phy_rx_clk);
		phy_col <= 1'b1;
		repeat (n) @(negedge phy_rx_clk);
		phy_col <= 1'b0;
	endtask
endmodule

// File: test/test_ethernet_phy_pin_interface.sv
// Self-checking bench for the PHY pin interface.
// Assumes the PHY model in ephy_phy_model and the package ephy_pkg.
`timescale 1ns/10ps
module test_ethernet_phy_pin_interface;
	import ephy_pkg::*;
	logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, phy_txd, phy_rxd;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic phy_tx_clk, phy_tx_en, phy_tx_err, phy_rx_clk, phy_rx_dv, phy_rx_err;
	logic phy_crs, phy_col, tx_valid, tx_err, tx_ready, rx_valid, rx_err, rx_end, cam_hit;
	logic [7:0] tx_data, rx_data;
	logic [8:0] rx_q[$];
	logic pc_q[$];
	logic [8:0] rxf[$], f[$];
	int err_count, checks, ends;

	ephy_pin_if i_dut (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .phy_tx_clk, .phy_txd,
		.phy_tx_en, .phy_tx_err, .phy_rx_clk, .phy_rxd, .phy_rx_dv, .phy_rx_err,
		.phy_crs, .phy_col, .tx_valid, .tx_data, .tx_err, .tx_ready, .rx_valid,
		.rx_data, .rx_err, .rx_end, .cam_hit);
	ephy_phy_model i_phy (.phy_tx_clk, .phy_rx_clk, .phy_txd, .phy_tx_en, .phy_tx_err,
		.phy_rxd, .phy_rx_dv, .phy_rx_err, .phy_crs, .phy_col);

	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (rx_valid === 1'b1) begin
			rx_q.push_back({rx_err, rx_data});
			pc_q.push_back(phy_tx_err);
		end
		if (rx_end === 1'b1) begin
			ends++;
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic send_tx(input logic [8:0] b[$]);
		foreach (b[i]) begin
			{tx_err, tx_data} <= b[i];
			tx_valid <= 1'b1;
			do @(posedge clk_sys); while (tx_ready !== 1'b1);
		end
		tx_valid <= 1'b0;
		do @(posedge clk_sys); while (phy_tx_en !== 1'b1);
		do @(posedge clk_sys); while (phy_tx_en !== 1'b0);
	endtask
	task automatic check_cap(input logic [8:0] b[$], input logic ser);
		int n;
		n = 0;
		foreach (b[i]) begin
			for (int k = 0; k < (ser ? 8 : 2); k++) begin
				check(ser ? {3'h0, i_phy.cap_q[n][1:0]} : i_phy.cap_q[n],
					ser ? {1'b1, b[i][k]} : {b[i][8], b[i][k*4 +: 4]});
				n++;
			end
		end
		check(i_phy.cap_q.size(), n);
		i_phy.cap_q.delete();
	endtask
	task automatic check_rx();
		repeat (30) @(posedge clk_sys);
		foreach (rxf[i]) check(rx_q[i], rxf[i]);
		check(rx_q.size(), rxf.size());
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{clk_sys, avs_address, avs_read, avs_write, avs_writedata} = '0;
		{tx_valid, tx_data, tx_err, cam_hit} = '0;
		sys_rst = 1'b1;
		rxf = '{9'h055, 9'h0d5, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h1a7, 9'h03c};
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		bus(0, EPHY_CTRL_ADDR, 0);
		check(rd, 0);
		bus(1, 4'hc, 32'hffff_ffff);
		bus(0, 4'hc, 0);
		check(rd, EPHY_RD_ZERO);
		f = '{9'h055, 9'h0d5, 9'h15a, 9'h0c3};
		send_tx(f);
		check_cap(f, 1'b0);
		i_phy.send(rxf, 1'b0);
		check_rx();
		// Every match, miss and polarity choice, with and without a hit
		for (int i = 0; i < 8; i++) begin
			bus(1, EPHY_CTRL_ADDR, {28'h0, i[1], i[0], i[2], 1'b1});
			cam_hit <= i[2];
			rx_q.delete();
			pc_q.delete();
			i_phy.send(rxf, 1'b1);
			check_rx();
			check(pc_q[1], i[1]);
			check(pc_q[8], i[1] ^ i[0] ^ i[2]);
			check(phy_tx_err, i[1]);
		end
		f = '{9'h0a5, 9'h03c};
		// Frame offered only once carrier is up, so it must wait it out
		fork
			i_phy.send(rxf, 1'b1);
			begin
				wait (phy_crs === 1'b1);
				repeat (4) @(posedge clk_sys);
				send_tx(f);
			end
			begin
				repeat (300) @(posedge clk_sys);
				check(phy_tx_en, 1'b0);
				check(i_phy.cap_q.size(), 0);
			end
		join
		check_cap(f, 1'b1);
		// Clear during a collision must lose to the set
		fork
			i_phy.collide(4);
			begin
				repeat (20) @(posedge clk_sys);
				bus(1, EPHY_STAT_ADDR, 32'h8);
				bus(0, EPHY_STAT_ADDR, 0);
				check(rd, 32'he);
			end
		join
		repeat (4) @(posedge clk_sys);
		bus(0, EPHY_STAT_ADDR, 0);
		check(rd, 32'hc);
		bus(1, EPHY_STAT_ADDR, 32'h8);
		bus(0, EPHY_STAT_ADDR, 0);
		check(rd, 32'h4);
		bus(1, EPHY_RXCNT_ADDR, 0);
		bus(0, EPHY_RXCNT_ADDR, 0);
		check(rd, 32'd10);
		check(ends, 32'd10);
		finish_test();
	end
	initial begin
		#1000000;
		err_count++;
		finish_test();
	end
endmodule
